// ==== lcdsd_decoder.sv ====
// serial frame parser and command decoder of the segment display controller
// assumes the host drives chip select, write and read strobes and data
// Behaviour
// - command id 100 then nine-bit codes repeat
// - id 110, address, return four nibble bits
// - id 101, address, store four bits
// - read-modify-write shares id 101
// - system disable stops oscillator and bias
// - system enable starts oscillator
// - bias generator off and on codes
// - time base output off and on
// - watchdog flag output off and on
// - buzzer outputs off and on
// - 0000-11xx clears time base count
// - 0000-111x clears watchdog count
// - clock source crystal, rc, external
// - bias half or third, common count
// - buzzer 4kHz or 2kHz select
// - time base rate 1Hz to 128Hz
// - power-on defaults and test mode codes
// - capture data on write strobe rising edge
// - chip select high aborts frame
// - event output enable and disable
`timescale 1ns/100ps
`include "lcdsd_defines.svh"
module lcdsd_decoder (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cs_b_pin,
  input wire logic wr_b_pin,
  input wire logic rd_b_pin,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  output lcdsd_pkg::lcdsd_cfg_t cfg,
  output logic timebase_clear,
  output logic watchdog_clear
);
  lcdsd_pkg::lcdsd_pins_t pins;
  logic [3:0] ram_rdata;
  logic ram_wr;
  logic [5:0] ram_addr;

  typedef struct packed {
    lcdsd_pkg::lcdsd_state_t state;
    logic [2:0] id;
    logic [3:0] cnt;
    logic [5:0] addr;
    logic [8:0] code;
    logic [3:0] nib;
    logic wr_d;
    logic rd_d;
    logic rmw;
    logic dout;
    logic oe;
    logic ram_wr;
    logic tb_clr;
    logic wd_clr;
    lcdsd_pkg::lcdsd_cfg_t cfg;
  } lcdsd_dec_st_t;
  lcdsd_dec_st_t st;
  lcdsd_dec_st_t next_st;

  // power-on configuration
  localparam lcdsd_pkg::lcdsd_cfg_t CFG_DEF = '{
    osc_on: 1'b0, bias_gen_on: 1'b0, timebase_out_on: 1'b0,
    watchdog_flag_on: 1'b0, buzzer_on: 1'b0, buzzer_low_freq: 1'b0,
    event_out_on: 1'b0, clk_src: `LCDSD_SRC_RC, bias_third: 1'b0,
    com_sel: `LCDSD_COM_DEF, rate_sel: `LCDSD_RATE_DEF, test_mode: 1'b0};

  lcdsd_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pins_in({cs_b_pin, wr_b_pin, rd_b_pin, data_in}),
    .pins_out(pins)
  );

  lcdsd_ram u_ram (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .wr_en(ram_wr),
    .addr(ram_addr),
    .wdata(st.nib),
    .rdata(ram_rdata)
  );

  // apply one nine-bit code to the configuration; x bits never looked at
  function automatic lcdsd_pkg::lcdsd_cfg_t apply_code(
    input lcdsd_pkg::lcdsd_cfg_t c, input logic [8:0] k);
    lcdsd_pkg::lcdsd_cfg_t r;
    r = c;
    casez (k[8:1])
      8'b0000_0000: begin
        r.osc_on = 1'b0;
        r.bias_gen_on = 1'b0;
      end
      8'b0000_0001: r.osc_on = 1'b1;
      8'b0000_0010: r.bias_gen_on = 1'b0;
      8'b0000_0011: r.bias_gen_on = 1'b1;
      8'b0000_0100: r.timebase_out_on = 1'b0;
      8'b0000_0110: r.timebase_out_on = 1'b1;
      8'b0000_0101: r.watchdog_flag_on = 1'b0;
      8'b0000_0111: r.watchdog_flag_on = 1'b1;
      8'b0000_1000: r.buzzer_on = 1'b0;
      8'b0000_1001: r.buzzer_on = 1'b1;
      8'b0001_01??: r.clk_src = `LCDSD_SRC_XTAL;
      8'b0001_10??: r.clk_src = `LCDSD_SRC_RC;
      8'b0001_11??: r.clk_src = `LCDSD_SRC_EXT;
      8'b0010_????: begin
        // ab=11 is not listed, so that code changes nothing
        if (k[4:3] != 2'h3) begin
          r.com_sel = k[4:3];
          r.bias_third = k[1];
        end
      end
      8'b010?_????: r.buzzer_low_freq = 1'b0;
      8'b011?_????: r.buzzer_low_freq = 1'b1;
      8'b100?_1???: r.event_out_on = 1'b1;
      8'b100?_0???: r.event_out_on = 1'b0;
      8'b101?_????: r.rate_sel = k[3:1];
      8'b1110_0000: r.test_mode = 1'b1;
      8'b1110_0011: r.test_mode = 1'b0;
      default: r = c;
    endcase
    return r;
  endfunction : apply_code

  logic wr_rise;
  logic rd_fall;
  logic wr_fall;
  assign wr_rise = pins.wr_b & ~st.wr_d;
  assign rd_fall = ~pins.rd_b & st.rd_d;
  assign wr_fall = ~pins.wr_b & st.wr_d;

  // frame parser on strobe edges seen in the system clock
  always_comb begin
    next_st = st;
    next_st.wr_d = pins.wr_b;
    next_st.rd_d = pins.rd_b;
    next_st.ram_wr = 1'b0;
    next_st.tb_clr = 1'b0;
    next_st.wd_clr = 1'b0;
    if (pins.cs_b) begin
      next_st.state = lcdsd_pkg::ST_ID;
      next_st.cnt = '0;
      next_st.id = '0;
      next_st.oe = 1'b0;
    end else begin
      case (st.state)
        lcdsd_pkg::ST_ID: begin
          if (wr_rise) begin
            next_st.id = {st.id[1:0], pins.data};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'h2) begin
              next_st.cnt = '0;
              next_st.rmw = 1'b0;
              case ({st.id[1:0], pins.data})
                `LCDSD_ID_CMD: next_st.state = lcdsd_pkg::ST_CODE;
                `LCDSD_ID_READ: next_st.state = lcdsd_pkg::ST_ADDR;
                `LCDSD_ID_WRITE: next_st.state = lcdsd_pkg::ST_ADDR;
                default: next_st.state = lcdsd_pkg::ST_IDLE;
              endcase
            end
          end
        end
        lcdsd_pkg::ST_ADDR: begin
          if (wr_rise) begin
            next_st.addr = {st.addr[4:0], pins.data};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'h5) begin
              next_st.cnt = '0;
              next_st.state = (st.id == `LCDSD_ID_READ) ?
                lcdsd_pkg::ST_RDATA : lcdsd_pkg::ST_DATA;
            end
          end
        end
        lcdsd_pkg::ST_RDATA: begin
          // bit put out on read strobe falling edge, d0 first
          if (rd_fall) begin
            next_st.oe = 1'b1;
            next_st.dout = ram_rdata[st.cnt[1:0]];
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'h3) begin
              next_st.cnt = '0;
              if (st.id == `LCDSD_ID_WRITE) begin
                // address held so the write lands on the nibble just read
                next_st.rmw = 1'b1;
                next_st.state = lcdsd_pkg::ST_DATA;
              end else begin
                next_st.addr = st.addr + 6'h1;
              end
            end
          end else if (wr_fall && st.id == `LCDSD_ID_WRITE) begin
            // short read: line handed back before the first write bit lands
            next_st.oe = 1'b0;
            next_st.cnt = '0;
            next_st.rmw = 1'b1;
            next_st.state = lcdsd_pkg::ST_DATA;
          end
        end
        lcdsd_pkg::ST_DATA: begin
          // read strobe in a write frame reads first: read-modify-write
          if (rd_fall && st.cnt == 4'h0 && !st.rmw) begin
            next_st.oe = 1'b1;
            next_st.dout = ram_rdata[0];
            next_st.cnt = 4'h1;
            next_st.state = lcdsd_pkg::ST_RDATA;
          end else if (wr_rise) begin
            next_st.oe = 1'b0;
            next_st.nib[st.cnt[1:0]] = pins.data;
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'h3) begin
              next_st.cnt = '0;
              next_st.ram_wr = 1'b1;
              next_st.rmw = 1'b0;
              next_st.addr = st.addr + 6'h1;
            end
          end else if (wr_fall) begin
            // host owns the line from the first write strobe on
            next_st.oe = 1'b0;
          end
        end
        lcdsd_pkg::ST_CODE: begin
          if (wr_rise) begin
            next_st.code = {st.code[7:0], pins.data};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'h8) begin
              next_st.cnt = '0;
              next_st.cfg = apply_code(st.cfg, {st.code[7:0], pins.data});
              next_st.tb_clr = (st.code[7:2] == 6'h03);
              next_st.wd_clr = (st.code[7:1] == 7'h07);
            end
          end
        end
        default: next_st.state = lcdsd_pkg::ST_IDLE;
      endcase
    end
  end

  // ram write after the fourth bit; address advances for successive nibbles
  assign ram_wr = st.ram_wr;
  assign ram_addr = st.ram_wr ? (st.addr - 6'h1) : st.addr;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.state <= lcdsd_pkg::ST_ID;
      st.wr_d <= 1'b1;
      st.rd_d <= 1'b1;
      st.cfg <= CFG_DEF;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign data_out = st.dout;
  assign data_oe = st.oe;
  assign cfg = st.cfg;
  assign timebase_clear = st.tb_clr;
  assign watchdog_clear = st.wd_clr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_cs_high;
    clk_en && pins.cs_b;
  endsequence
  property p_abort;
    s_cs_high |=> st.state == lcdsd_pkg::ST_ID && !data_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not aborted");

  property p_sysdis;
    clk_en && !pins.cs_b && wr_rise && st.state == lcdsd_pkg::ST_CODE && st.cnt == 4'h8
      && st.code[7:0] == 8'h00 |=> !cfg.osc_on && !cfg.bias_gen_on;
  endproperty
  a_sysdis: assert property (p_sysdis) else $error("disable code ignored");

  property p_tbclr;
    timebase_clear |-> $past(st.code[7:2]) == 6'h03 || st.code[8:3] == 6'h03;
  endproperty
  a_tbclr: assert property (p_tbclr) else $error("stray time base clear");

  property p_wdclr;
    watchdog_clear |-> timebase_clear;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("watchdog clear alone");

  property p_pulse;
    timebase_clear |=> !timebase_clear;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear longer than one");

  property p_cfg_stable;
    clk_en && st.state != lcdsd_pkg::ST_CODE |=> $stable(cfg);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config moved");

  property p_ramwr;
    ram_wr |-> $past(st.state) == lcdsd_pkg::ST_DATA;
  endproperty
  a_ramwr: assert property (p_ramwr) else $error("write outside data");

  property p_srcdef;
    $rose(rst_b) |-> cfg.clk_src == `LCDSD_SRC_RC;
  endproperty
  a_srcdef: assert property (p_srcdef) else $error("bad default source");

  property p_oe;
    data_oe |-> st.state inside {lcdsd_pkg::ST_RDATA, lcdsd_pkg::ST_DATA};
  endproperty
  a_oe: assert property (p_oe) else $error("drive outside read");

  property p_release;
    clk_en && !pins.cs_b && wr_fall && st.state == lcdsd_pkg::ST_DATA |=> !data_oe;
  endproperty
  a_release: assert property (p_release) else $error("data line not released");
endmodule : lcdsd_decoder

// ==== lcdsd_defines.svh ====
// constants for the serial command decoder of the segment display controller
// assumes inclusion by bare name from the package and modules
`ifndef LCDSD_DEFINES_SVH
`define LCDSD_DEFINES_SVH
`define LCDSD_ID_CMD 3'h4
`define LCDSD_ID_READ 3'h6
`define LCDSD_ID_WRITE 3'h5
`define LCDSD_ADDR_W 6
`define LCDSD_NIB_W 4
`define LCDSD_CODE_W 9
`define LCDSD_RAM_DEPTH 32
`define LCDSD_RATE_DEF 3'h7
`define LCDSD_SRC_XTAL 2'h1
`define LCDSD_SRC_RC 2'h2
`define LCDSD_SRC_EXT 2'h3
`define LCDSD_COM_DEF 2'h0
`endif

// ==== lcdsd_host.sv ====
// host model: drives chip select, write and read strobes and the data line
// assumes strobe phases of six clk_sys cycles clear the pin synchroniser
`timescale 1ns/100ps
module lcdsd_host (
  input wire logic clk_sys,
  input wire logic dev_dout,
  input wire logic dev_oe,
  output logic cs_b,
  output logic wr_b,
  output logic rd_b,
  output logic data_line
);
  logic host_d;
  logic host_oe;
  // released line shows the inverse of the last bit, never a held value
  assign data_line = dev_oe ? dev_dout : (host_oe ? host_d : ~host_d);
  initial begin
    cs_b = 1'b1;
    wr_b = 1'b1;
    rd_b = 1'b1;
    host_d = 1'b0;
    host_oe = 1'b1;
  end
  // all pin changes land 5 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : tick
  // high pulse between frames resets the parser
  task automatic sel(input logic on);
    cs_b = ~on;
    host_oe = 1'b1;
    tick(8);
  endtask : sel
  task automatic put_bit(input logic b);
    host_oe = 1'b1;
    host_d = b;
    wr_b = 1'b0;
    tick(6);
    wr_b = 1'b1;
    tick(6);
  endtask : put_bit
  // sample after the rising read edge, well before the next fall
  task automatic get_bit(output logic b);
    host_oe = 1'b0;
    rd_b = 1'b0;
    tick(6);
    rd_b = 1'b1;
    tick(1);
    b = data_line;
    tick(5);
  endtask : get_bit
endmodule : lcdsd_host

// ==== lcdsd_pkg.sv ====
// types shared by the serial command decoder modules
// assumes lcdsd_defines.svh is on the include path
`include "lcdsd_defines.svh"
package lcdsd_pkg;
  typedef enum logic [2:0] {
    ST_ID,
    ST_ADDR,
    ST_DATA,
    ST_CODE,
    ST_RDATA,
    ST_IDLE
  } lcdsd_state_t;

  // configuration the command codes steer
  typedef struct packed {
    logic osc_on;
    logic bias_gen_on;
    logic timebase_out_on;
    logic watchdog_flag_on;
    logic buzzer_on;
    logic buzzer_low_freq;
    logic event_out_on;
    logic [1:0] clk_src;
    logic bias_third;
    logic [1:0] com_sel;
    logic [2:0] rate_sel;
    logic test_mode;
  } lcdsd_cfg_t;

  // the four serial pins after synchronising
  typedef struct packed {
    logic cs_b;
    logic wr_b;
    logic rd_b;
    logic data;
  } lcdsd_pins_t;
endpackage : lcdsd_pkg

// ==== lcdsd_ram.sv ====
// 32 x 4 display memory, one write port and one registered read port
// assumes addresses above depth wrap by truncation
`timescale 1ns/100ps
`include "lcdsd_defines.svh"
module lcdsd_ram (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [5:0] addr,
  input wire logic [3:0] wdata,
  output logic [3:0] rdata
);
  typedef struct packed {
    logic [`LCDSD_RAM_DEPTH-1:0][3:0] mem;
    logic [3:0] rdata;
  } lcdsd_ram_st_t;
  lcdsd_ram_st_t st;
  lcdsd_ram_st_t next_st;

  // read is of the old contents, so read-modify-write sees prior data
  always_comb begin
    next_st = st;
    next_st.rdata = st.mem[addr[4:0]];
    if (wr_en) begin
      next_st.mem[addr[4:0]] = wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
endmodule : lcdsd_ram

// ==== lcdsd_sync.sv ====
// three-stage synchroniser for the serial pins with agreement filter
// assumes pins are asynchronous to clk_sys
`timescale 1ns/100ps
module lcdsd_sync (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire lcdsd_pkg::lcdsd_pins_t pins_in,
  output lcdsd_pkg::lcdsd_pins_t pins_out
);
  typedef struct packed {
    lcdsd_pkg::lcdsd_pins_t s1;
    lcdsd_pkg::lcdsd_pins_t s2;
    lcdsd_pkg::lcdsd_pins_t s3;
    lcdsd_pkg::lcdsd_pins_t filt;
  } lcdsd_sync_st_t;
  lcdsd_sync_st_t st;
  lcdsd_sync_st_t next_st;

  // stage one only feeds stage two; filter takes only agreeing stages
  always_comb begin
    next_st = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 4; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s2[i];
      end
    end
  end

  // idle pins reset high except data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= {4{4'he}};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign pins_out = st.filt;
endmodule : lcdsd_sync

// ==== tb.sv ====
// self-checking bench for the serial command decoder
// assumes lcdsd_host as the far-side model and a 100 ns clk_sys
`timescale 1ns/100ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t %s", $time, m); end end
module tb;
  logic clk_sys;
  logic rst_b;
  logic clk_en;
  logic cs_b, wr_b, rd_b, data_line, data_out, data_oe, tb_clr, wd_clr;
  lcdsd_pkg::lcdsd_cfg_t cfg;
  lcdsd_pkg::lcdsd_cfg_t exp_cfg;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_tb = 0;
  int n_wd = 0;
  logic [3:0] nib;
  logic [8:0] codes [0:30] = '{9'h008, 9'h00a, 9'h09f, 9'h040, 9'h003, 9'h007, 9'h00c,
    9'h00e, 9'h012, 9'h0c0, 9'h028, 9'h03e, 9'h04a, 9'h05a, 9'h050, 9'h13e, 9'h100, 9'h110,
    9'h1c0, 9'h180, 9'h1c2, 9'h1c6, 9'h018, 9'h01a, 9'h01c, 9'h01f, 9'h030, 9'h010,
    9'h004, 9'h003, 9'h000};

  lcdsd_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .cs_b_pin(cs_b),
    .wr_b_pin(wr_b), .rd_b_pin(rd_b), .data_in(data_line), .data_out(data_out),
    .data_oe(data_oe), .cfg(cfg), .timebase_clear(tb_clr), .watchdog_clear(wd_clr));
  lcdsd_host host (.clk_sys(clk_sys), .dev_dout(data_out), .dev_oe(data_oe), .cs_b(cs_b),
    .wr_b(wr_b), .rd_b(rd_b), .data_line(data_line));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // clear pulses are one cycle wide, so count them as they pass
  always @(posedge clk_sys) begin
    if (tb_clr === 1'b1) n_tb++;
    if (wd_clr === 1'b1) n_wd++;
  end

  // expected configuration after one command code
  function automatic lcdsd_pkg::lcdsd_cfg_t model(lcdsd_pkg::lcdsd_cfg_t c, logic [8:0] k);
    casez (k)
      9'b0000_0000_?: begin
        c.osc_on = 1'b0;
        c.bias_gen_on = 1'b0;
      end
      9'b0000_0001_?: c.osc_on = 1'b1;
      9'b0000_001?_?: c.bias_gen_on = k[1];
      9'b0000_01?0_?: c.timebase_out_on = k[2];
      9'b0000_01?1_?: c.watchdog_flag_on = k[2];
      9'b0000_100?_?: c.buzzer_on = k[1];
      9'b0001_????_?: if (k[4:3] != 2'h0) c.clk_src = k[4:3];
      9'b0010_????_?: if (k[4:3] != 2'h3) begin
        c.com_sel = k[4:3];
        c.bias_third = k[1];
      end
      9'b01??_????_?: c.buzzer_low_freq = k[6];
      9'b100?_????_?: c.event_out_on = k[4];
      9'b101?_????_?: c.rate_sel = k[3:1];
      9'b1110_0000_?: c.test_mode = 1'b1;
      9'b1110_0011_?: c.test_mode = 1'b0;
      default: ;
    endcase
    return c;
  endfunction : model

  task automatic send(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) host.put_bit(v[i]);
  endtask : send
  task automatic wr_nib(input logic [3:0] v);
    for (int i = 0; i < 4; i++) host.put_bit(v[i]);
  endtask : wr_nib
  task automatic rd_nib(input logic [3:0] e);
    for (int i = 0; i < 4; i++) host.get_bit(nib[i]);
    `CHK(nib, e, "read nibble")
  endtask : rd_nib
  task automatic do_cmd(input logic [8:0] k, input bit chk);
    int t0;
    int w0;
    t0 = n_tb;
    w0 = n_wd;
    send(k, 9);
    exp_cfg = model(exp_cfg, k);
    if (chk) `CHK(cfg, exp_cfg, "config after code")
    `CHK(n_tb - t0, int'(k[8:3] == 6'h03), "time base clear pulses")
    `CHK(n_wd - w0, int'(k[8:2] == 7'h07), "watchdog clear pulses")
  endtask : do_cmd
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // a hang is cut far beyond the few thousand cycles the tests need
  initial begin
    #5000000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    exp_cfg = '0;
    exp_cfg.clk_src = 2'h2;
    exp_cfg.rate_sel = 3'h7;
    repeat (8) @(posedge clk_sys);
    #5 rst_b = 1'b1;
    host.tick(6);
    `CHK({cfg.osc_on, cfg.bias_gen_on, cfg.buzzer_on, cfg.clk_src, cfg.event_out_on,
      cfg.rate_sel, cfg.test_mode}, 10'h04e, "power-on defaults")
    host.sel(1'b1);
    send(3'h4, 3);
    // first four codes settle fields with no documented default
    for (int i = 0; i < 31; i++) do_cmd(codes[i], i >= 4);
    for (int r = 0; r < 8; r++) do_cmd({5'h14, 3'(r), 1'b0}, 1'b1);
    // clock enable low freezes the parser, so a whole code passes unseen
    clk_en = 1'b0;
    send(9'h003, 9);
    clk_en = 1'b1;
    host.tick(6);
    `CHK(cfg, exp_cfg, "code seen while frozen")
    do_cmd(9'h003, 1'b1);
    host.sel(1'b0);
    // partial code then deselect: nothing may change
    host.sel(1'b1);
    send(3'h4, 3);
    send(9'h001, 5);
    host.sel(1'b0);
    `CHK(cfg, exp_cfg, "aborted command")
    host.sel(1'b1);
    send(3'h5, 3);
    send(6'h1e, 6);
    wr_nib(4'ha);
    wr_nib(4'h5);
    host.sel(1'b0);
    host.sel(1'b1);
    send(3'h6, 3);
    send(6'h1e, 6);
    rd_nib(4'ha);
    rd_nib(4'h5);
    host.sel(1'b0);
    `CHK(data_oe, 1'b0, "data line released")
    host.sel(1'b1);
    send(3'h5, 3);
    send(6'h1e, 6);
    rd_nib(4'ha);
    wr_nib(4'h3);
    host.sel(1'b0);
    host.sel(1'b1);
    send(3'h5, 3);
    send(6'h1e, 6);
    send(9'h003, 2);
    host.sel(1'b0);
    host.sel(1'b1);
    send(3'h6, 3);
    send(6'h1e, 6);
    rd_nib(4'h3);
    host.sel(1'b0);
    // reset in mid-run brings every default back
    rst_b = 1'b0;
    host.tick(2);
    rst_b = 1'b1;
    host.tick(6);
    exp_cfg = '0;
    exp_cfg.clk_src = 2'h2;
    exp_cfg.rate_sel = 3'h7;
    `CHK(cfg, exp_cfg, "defaults after reset")
    finish_test();
  end
endmodule : tb
